// ==== core/sea_pkg.sv ====
package sea_pkg;
	localparam logic [11:0] SEA_PRIMARY_OFF   = 12'h110;
	localparam logic [11:0] SEA_SECONDARY_OFF = 12'h114;
	localparam logic [11:0] SEA_EDGE_CFG_OFF  = 12'h118;
	localparam logic [11:0] SEA_EVENT_OFF     = 12'h11c;
	localparam logic [11:0] SEA_SUMMARY_OFF   = 12'h120;
	// primary word fields
	localparam int SEA_P_FIELD_A = 8;
	localparam int SEA_P_FIELD_B = 7;
	localparam int SEA_P_GP      = 3;
	localparam int SEA_P_CGRP    = 2;
	localparam int SEA_P_EC3  = 1;
	localparam int SEA_P_EC0  = 0;
	// secondary word fields
	localparam int SEA_S_REQ  = 31;
	localparam int SEA_S_MST  = 30;
	localparam int SEA_S_RE1  = 29;
	localparam int SEA_S_PE1  = 28;
	localparam int SEA_S_A1   = 27;
	localparam int SEA_S_RE0  = 26;
	localparam int SEA_S_PE0  = 25;
	localparam int SEA_S_A0   = 24;
	localparam int SEA_S_TO   = 23;
	localparam int SEA_S_EF   = 22;
	localparam int SEA_S_IIC  = 17;
	localparam int SEA_S_VP   = 14;
	localparam int SEA_S_VFIFO3 = 13;
	localparam int SEA_S_EC   = 0;
	// summary register fields
	localparam int SEA_M_XBUS = 0;
	localparam int SEA_M_TWI  = 1;
	localparam int SEA_M_SEQ0 = 2;
	localparam int SEA_M_SEQ1 = 3;
	localparam int SEA_M_VPE  = 4;
	localparam int SEA_M_VFIFO = 5;
	// reset values
	localparam logic [31:0] SEA_EDGE_CFG_RST = 32'h0000_0000;
	localparam logic        SEA_TIMEOUT_RST  = 1'b1;
	// edge select encodings, two bits per source
	localparam logic [1:0] SEA_EDGE_NONE = 2'h0;
	localparam logic [1:0] SEA_EDGE_RISE = 2'h1;
	localparam logic [1:0] SEA_EDGE_FALL = 2'h2;
	localparam logic [1:0] SEA_EDGE_BOTH = 2'h3;

	// sequencer task events
	typedef struct packed {
		logic start;
		logic reg_error;
		logic page_error;
		logic executing;
	} sea_seq_t;

	// serial bus master events
	typedef struct packed {
		logic cmd_start;
		logic addr_nack;
		logic write_nack;
		logic read_nack;
		logic arb_lost;
		logic frame_error;
	} sea_twi_t;

	// external data bus events
	typedef struct packed {
		logic cmd_start;
		logic timeout;
		logic format_error;
	} sea_xbus_t;

	// clear strobes from the interrupt status register, write-one pulses
	typedef struct packed {
		logic seq1_err;
		logic seq0_err;
		logic xbus;
		logic twi;
		logic vdma_prot;
		logic vfifo;
		logic counters;
	} sea_clr_t;
endpackage

// ==== core/sea_top.sv ====
`timescale 1ns/1ns
module sea_top
	import sea_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        field_id_a,
	input  wire logic        field_id_b,
	input  wire logic [3:0]  gp_pin,
	input  wire logic [5:0]  counter_over,
	input  wire logic        bus_req,
	input  wire logic        bus_gnt,
	input  wire logic        bus_master,
	input  sea_seq_t         seq0,
	input  sea_seq_t         seq1,
	input  sea_xbus_t        xbus,
	input  sea_twi_t         twi,
	input  wire logic [2:0]  vdma_prot_hit,
	input  wire logic        vdma_reload,
	input  wire logic        vfifo3_xrun_hit,
	input  sea_clr_t         isr_clear,
	output logic      [5:0]  edge_event
);

	// ******************************************
	// status state
	// ******************************************
	logic [31:0] edge_cfg;
	logic [31:0] next_edge_cfg;
	logic [5:0]  src_q;
	logic [5:0]  next_src_q;
	logic [5:0]  next_edge_event;
	logic [3:0]  counter_flags;
	logic [3:0]  next_counter_flags;
	logic        counter3_flag;
	logic        next_counter3_flag;
	logic        counter0_flag;
	logic        next_counter0_flag;
	logic        bus_request_pending;
	logic        next_bus_request_pending;
	logic        bus_master_active;
	logic        next_bus_master_active;
	logic        seq1_reg_error;
	logic        next_seq1_reg_error;
	logic        seq1_page_error;
	logic        next_seq1_page_error;
	logic        seq1_active;
	logic        next_seq1_active;
	logic        seq0_reg_error;
	logic        next_seq0_reg_error;
	logic        seq0_page_error;
	logic        next_seq0_page_error;
	logic        seq0_active;
	logic        next_seq0_active;
	logic        xbus_timeout_flag;
	logic        next_xbus_timeout_flag;
	logic        xbus_format_error;
	logic        next_xbus_format_error;
	logic        xbus_event_summary;
	logic        next_xbus_event_summary;
	logic [4:0]  twi_flags;
	logic [4:0]  next_twi_flags;
	logic        twi_error_summary;
	logic        next_twi_error_summary;
	logic [2:0]  vdma_prot;
	logic [2:0]  next_vdma_prot;
	logic        vfifo3_xrun;
	logic        next_vfifo3_xrun;
	logic [5:0]  src_now;
	logic [4:0]  twi_hits;
	logic [31:0] primary_status_word;
	logic [31:0] secondary_status_word;
	logic [31:0] summary_word;

	// ******************************************
	// status words
	// ******************************************
	assign src_now  = {field_id_a, field_id_b, gp_pin};
	assign twi_hits = {twi.addr_nack, twi.write_nack, twi.read_nack,
		twi.arb_lost, twi.frame_error};

	always_comb begin
		primary_status_word = 32'h0000_0000;
		primary_status_word[SEA_P_FIELD_A] = src_q[5];
		primary_status_word[SEA_P_FIELD_B] = src_q[4];
		primary_status_word[SEA_P_GP +: 4] = src_q[3:0];
		primary_status_word[SEA_P_CGRP] = |counter_flags;
		primary_status_word[SEA_P_EC3] = counter3_flag;
		primary_status_word[SEA_P_EC0] = counter0_flag;
	end

	always_comb begin
		secondary_status_word = 32'h0000_0000;
		secondary_status_word[SEA_S_REQ] = bus_request_pending;
		secondary_status_word[SEA_S_MST] = bus_master_active;
		secondary_status_word[SEA_S_RE1] = seq1_reg_error;
		secondary_status_word[SEA_S_PE1] = seq1_page_error;
		secondary_status_word[SEA_S_A1]  = seq1_active;
		secondary_status_word[SEA_S_RE0] = seq0_reg_error;
		secondary_status_word[SEA_S_PE0] = seq0_page_error;
		secondary_status_word[SEA_S_A0]  = seq0_active;
		secondary_status_word[SEA_S_TO]  = xbus_timeout_flag;
		secondary_status_word[SEA_S_EF]  = xbus_format_error;
		secondary_status_word[SEA_S_IIC +: 5] = twi_flags;
		secondary_status_word[SEA_S_VP +: 3]  = vdma_prot;
		secondary_status_word[SEA_S_VFIFO3] = vfifo3_xrun;
		secondary_status_word[SEA_S_EC +: 4]  = counter_flags;
	end

	always_comb begin
		summary_word = 32'h0000_0000;
		summary_word[SEA_M_XBUS] = xbus_event_summary;
		summary_word[SEA_M_TWI]  = twi_error_summary;
		summary_word[SEA_M_SEQ0] = seq0_reg_error | seq0_page_error;
		summary_word[SEA_M_SEQ1] = seq1_reg_error | seq1_page_error;
		summary_word[SEA_M_VPE]  = |vdma_prot;
		summary_word[SEA_M_VFIFO] = vfifo3_xrun;
	end

	// ******************************************
	// next state of the status bits
	// ******************************************
	// every sticky flag: set term ored last so a same-cycle set wins
	always_comb begin
		next_src_q = src_now;
		for (int i = 0; i < 6; i++) begin
			case (edge_cfg[2*i +: 2])
			SEA_EDGE_RISE: next_edge_event[i] = src_now[i] & ~src_q[i];
			SEA_EDGE_FALL: next_edge_event[i] = ~src_now[i] & src_q[i];
			SEA_EDGE_BOTH: next_edge_event[i] = src_now[i] ^ src_q[i];
			default:       next_edge_event[i] = 1'b0;
			endcase
		end
		// counter 1,2,4,5 flags cleared only by the group isr bit
		next_counter_flags = (counter_flags & {4{~isr_clear.counters}})
			| {counter_over[5], counter_over[4],
			counter_over[2], counter_over[1]};
		next_counter3_flag = counter_over[3];
		next_counter0_flag = counter_over[0];
		next_bus_request_pending = bus_req & ~bus_gnt;
		next_bus_master_active = bus_master;
		next_seq1_reg_error = (seq1_reg_error & ~isr_clear.seq1_err
			& ~seq1.start) | seq1.reg_error;
		next_seq0_reg_error = (seq0_reg_error & ~isr_clear.seq0_err
			& ~seq0.start) | seq0.reg_error;
		next_seq1_page_error = (seq1_page_error & ~isr_clear.seq1_err
			& ~seq1.start) | seq1.page_error;
		next_seq0_page_error = (seq0_page_error & ~isr_clear.seq0_err
			& ~seq0.start) | seq0.page_error;
		next_seq1_active = seq1.executing;
		next_seq0_active = seq0.executing;
		next_xbus_timeout_flag = (xbus_timeout_flag & ~isr_clear.xbus)
			| xbus.timeout;
		next_xbus_format_error = (xbus_format_error & ~isr_clear.xbus)
			| xbus.format_error;
		next_xbus_event_summary = (xbus_event_summary & ~xbus.cmd_start)
			| next_xbus_timeout_flag | next_xbus_format_error;
		next_twi_flags = (twi_flags & {5{~(isr_clear.twi | twi.cmd_start)}})
			| twi_hits;
		next_twi_error_summary = (twi_error_summary & ~twi.cmd_start)
			| (|next_twi_flags);
		next_vdma_prot = (vdma_prot
			& {3{~(isr_clear.vdma_prot | vdma_reload)}})
			| vdma_prot_hit;
		next_vfifo3_xrun = (vfifo3_xrun & ~(isr_clear.vfifo | vdma_reload))
			| vfifo3_xrun_hit;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			src_q               <= 6'h00;
			edge_event          <= 6'h00;
			counter_flags       <= 4'h0;
			counter3_flag       <= 1'b0;
			counter0_flag       <= 1'b0;
			bus_request_pending <= 1'b0;
			bus_master_active   <= 1'b0;
			seq1_reg_error      <= 1'b0;
			seq1_page_error     <= 1'b0;
			seq1_active         <= 1'b0;
			seq0_reg_error      <= 1'b0;
			seq0_page_error     <= 1'b0;
			seq0_active         <= 1'b0;
			xbus_timeout_flag   <= SEA_TIMEOUT_RST;
			xbus_format_error   <= 1'b0;
			xbus_event_summary  <= SEA_TIMEOUT_RST;
			twi_flags           <= 5'h00;
			twi_error_summary   <= 1'b0;
			vdma_prot           <= 3'h0;
			vfifo3_xrun         <= 1'b0;
		end else begin
			src_q               <= next_src_q;
			edge_event          <= next_edge_event;
			counter_flags       <= next_counter_flags;
			counter3_flag       <= next_counter3_flag;
			counter0_flag       <= next_counter0_flag;
			bus_request_pending <= next_bus_request_pending;
			bus_master_active   <= next_bus_master_active;
			seq1_reg_error      <= next_seq1_reg_error;
			seq1_page_error     <= next_seq1_page_error;
			seq1_active         <= next_seq1_active;
			seq0_reg_error      <= next_seq0_reg_error;
			seq0_page_error     <= next_seq0_page_error;
			seq0_active         <= next_seq0_active;
			xbus_timeout_flag   <= next_xbus_timeout_flag;
			xbus_format_error   <= next_xbus_format_error;
			xbus_event_summary  <= next_xbus_event_summary;
			twi_flags           <= next_twi_flags;
			twi_error_summary   <= next_twi_error_summary;
			vdma_prot           <= next_vdma_prot;
			vfifo3_xrun         <= next_vfifo3_xrun;
		end
	end

	// ******************************************
	// apb slave
	// ******************************************
	// one wait-free access phase: answer registered in the setup cycle
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;
	logic        setup;
	logic        known;

	assign setup = psel & ~penable & ~pready;

	always_comb begin
		next_edge_cfg = edge_cfg;
		next_prdata   = 32'h0000_0000;
		next_pready   = 1'b0;
		next_pslverr  = 1'b0;
		known         = 1'b1;
		case (paddr)
		SEA_PRIMARY_OFF:   next_prdata = primary_status_word;
		SEA_SECONDARY_OFF: next_prdata = secondary_status_word;
		SEA_EDGE_CFG_OFF:  next_prdata = edge_cfg;
		SEA_EVENT_OFF:     next_prdata = {26'h0, edge_event};
		SEA_SUMMARY_OFF:   next_prdata = summary_word;
		default:           known = 1'b0;
		endcase
		if (setup) begin
			next_pready  = 1'b1;
			next_pslverr = ~known;
			if (pwrite) begin
				next_prdata = 32'h0000_0000;
			end
		end else begin
			next_prdata = 32'h0000_0000;
		end
		// write lands at the edge that sees pready; status words ignore it
		if (psel & penable & pready & pwrite
			& (paddr == SEA_EDGE_CFG_OFF)) begin
			next_edge_cfg = {20'h0, pwdata[11:0]};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			edge_cfg <= SEA_EDGE_CFG_RST;
			prdata   <= 32'h0000_0000;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
		end else begin
			edge_cfg <= next_edge_cfg;
			prdata   <= next_prdata;
			pready   <= next_pready;
			pslverr  <= next_pslverr;
		end
	end

endmodule

// ==== verif/sea_top_sva.sv ====
`timescale 1ns/1ns
module sea_top_sva
	import sea_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rst_b,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        field_id_a,
	input wire logic        field_id_b,
	input wire logic [3:0]  gp_pin,
	input wire logic [5:0]  edge_event
);
	logic mapped;
	assign mapped = paddr inside {SEA_PRIMARY_OFF, SEA_SECONDARY_OFF,
		SEA_EDGE_CFG_OFF, SEA_EVENT_OFF, SEA_SUMMARY_OFF};
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// ****
	// bus answers
	// ****
	property p_ready_after_setup;
		psel && !penable |=> pready;
	endproperty
	a_ready_after_setup: assert property (p_ready_after_setup)
		else $error("no ready after setup");
	property p_ready_in_access;
		pready |-> psel && penable && $past(psel && !penable);
	endproperty
	a_ready_in_access: assert property (p_ready_in_access)
		else $error("ready outside access");
	property p_err_empty;
		pslverr |-> pready && prdata == 32'h0;
	endproperty
	a_err_empty: assert property (p_err_empty)
		else $error("bad error answer");
	property p_unmapped_err;
		pready && !mapped |-> pslverr;
	endproperty
	a_unmapped_err: assert property (p_unmapped_err)
		else $error("unmapped without error");
	property p_status_write_ok;
		pready && mapped |-> !pslverr;
	endproperty
	a_status_write_ok: assert property (p_status_write_ok)
		else $error("error on mapped access");
	property p_data_idle;
		!pready || pwrite |-> prdata == 32'h0;
	endproperty
	a_data_idle: assert property (p_data_idle)
		else $error("read data outside read");
	// ****
	// edge events need a real pin change one cycle before
	// ****
	property p_edge_field_a;
		edge_event[5] |-> $past(field_id_a) != $past(field_id_a, 2);
	endproperty
	a_edge_field_a: assert property (p_edge_field_a)
		else $error("field a event without edge");
	property p_edge_field_b;
		edge_event[4] |-> $past(field_id_b) != $past(field_id_b, 2);
	endproperty
	a_edge_field_b: assert property (p_edge_field_b)
		else $error("field b event without edge");
	property p_edge_gp;
		(edge_event[3:0] & ~($past(gp_pin) ^ $past(gp_pin, 2))) == 4'h0;
	endproperty
	a_edge_gp: assert property (p_edge_gp)
		else $error("gp event without edge");
endmodule

bind sea_top sea_top_sva u_sva (.sys_clk(sys_clk), .rst_b(rst_b),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.field_id_a(field_id_a), .field_id_b(field_id_b), .gp_pin(gp_pin),
	.edge_event(edge_event));

// ==== verif/sea_top_test.sv ====
`timescale 1ns/1ns
module sea_top_test;
	import sea_pkg::*;
	logic        sys_clk, rst_b, psel, penable, pwrite, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, ex;
	logic        pready, pslverr, field_id_a, field_id_b;
	logic [3:0]  gp_pin;
	logic [5:0]  counter_over, edge_event;
	logic        bus_req, bus_gnt, bus_master, vdma_reload, vfifo3_xrun_hit;
	logic [2:0]  vdma_prot_hit;
	sea_seq_t    seq0, seq1;
	sea_xbus_t   xbus;
	sea_twi_t    twi;
	sea_clr_t    isr_clear;
	int          miscompares, compares, cycles;
	int          ks[12] = '{0, 1, 2, 3, 4, 5, 6, 7, 2, 8, 9, 10};
	logic [31:0] ms[12] = '{32'h30000000, 32'h06000000, 32'h00c00000,
		32'h003e0000, 32'h0001e000, 32'h0000000f, 32'h30000000,
		32'h06000000, 32'h00c00000, 32'h003e0000, 32'h0001c000, 32'h2000};

	sea_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.field_id_a(field_id_a), .field_id_b(field_id_b), .gp_pin(gp_pin),
		.counter_over(counter_over), .bus_req(bus_req), .bus_gnt(bus_gnt),
		.bus_master(bus_master), .seq0(seq0), .seq1(seq1), .xbus(xbus),
		.twi(twi), .vdma_prot_hit(vdma_prot_hit), .vdma_reload(vdma_reload),
		.vfifo3_xrun_hit(vfifo3_xrun_hit), .isr_clear(isr_clear),
		.edge_event(edge_event));

	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			end_of_test;
		end
	end
	// ****
	// bus and compare helpers
	// ****
	task end_of_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task rchk(input logic [11:0] a, input logic [31:0] m, e);
		apb(1'h0, a, 32'h0);
		chk(rd & m, e);
		chk({31'h0, er}, 32'h0);
	endtask
	// pulses last one cycle; levels stay
	task strobe;
		@(posedge sys_clk);
		seq0 <= seq0 & 4'h1;
		seq1 <= seq1 & 4'h1;
		xbus <= 3'h0;
		twi <= 6'h0;
		vdma_prot_hit <= 3'h0;
		vdma_reload <= 1'h0;
		vfifo3_xrun_hit <= 1'h0;
		isr_clear <= 7'h0;
		counter_over <= counter_over & 6'h09;
		repeat (2) @(posedge sys_clk);
	endtask
	task set_all;
		@(posedge sys_clk);
		seq0 <= seq0 | 4'h6;
		seq1 <= seq1 | 4'h6;
		xbus <= 3'h3;
		twi <= 6'h1f;
		vdma_prot_hit <= 3'h7;
		vfifo3_xrun_hit <= 1'h1;
		counter_over <= 6'h36;
		strobe;
		ex = 32'h36ffe00f;
	endtask
	task clr(input int k);
		@(posedge sys_clk);
		case (k)
			0: seq1.start <= 1'h1;
			1: isr_clear.seq0_err <= 1'h1;
			2: isr_clear.xbus <= 1'h1;
			3: twi.cmd_start <= 1'h1;
			4: vdma_reload <= 1'h1;
			5: isr_clear.counters <= 1'h1;
			6: isr_clear.seq1_err <= 1'h1;
			7: seq0.start <= 1'h1;
			8: isr_clear.twi <= 1'h1;
			9: isr_clear.vdma_prot <= 1'h1;
			default: isr_clear.vfifo <= 1'h1;
		endcase
		strobe;
	endtask
	task lv(input logic [1:0] f, co, input logic [3:0] g,
		input logic [2:0] b, input logic [1:0] x);
		@(posedge sys_clk);
		{field_id_a, field_id_b} <= f;
		gp_pin <= g;
		counter_over <= {2'h0, co[1], 2'h0, co[0]};
		{bus_req, bus_gnt, bus_master} <= b;
		{seq1.executing, seq0.executing} <= x;
		repeat (2) @(posedge sys_clk);
		rchk(SEA_PRIMARY_OFF, 32'h1ff, {23'h0, f, g, 1'h0, co});
		rchk(SEA_SECONDARY_OFF, 32'hc9000000, {b[2] & !b[1], b[0], 2'h0,
			x[1], 2'h0, x[0], 24'h0});
	endtask
	// ****
	// scenarios
	// ****
	task t_reset;
		rchk(SEA_SECONDARY_OFF, 32'hffffffff, 32'h00800000);
		rchk(SEA_SUMMARY_OFF, 32'h1, 32'h1);
		rchk(SEA_EDGE_CFG_OFF, 32'hffffffff, 32'h0);
		rchk(SEA_EVENT_OFF, 32'h3f, 32'h0);
		apb(1'h0, 12'h124, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, er}, 32'h1);
		$display("test reset done");
	endtask
	task t_levels;
		lv(2'h2, 2'h2, 4'ha, 3'h5, 2'h2);
		lv(2'h1, 2'h1, 4'h5, 3'h7, 2'h1);
		lv(2'h0, 2'h0, 4'h0, 3'h6, 2'h0);
		$display("test levels done");
	endtask
	task t_sticky;
		clr(2);
		rchk(SEA_SECONDARY_OFF, 32'h00800000, 32'h0);
		@(posedge sys_clk);
		xbus.cmd_start <= 1'h1;
		strobe;
		rchk(SEA_SUMMARY_OFF, 32'h1, 32'h0);
		for (int i = 0; i < 12; i++) begin
			if (i == 0 || i == 6)
				set_all;
			if (i == 0)
				apb(1'h1, SEA_SECONDARY_OFF, 32'h0);
			if (i == 0)
				apb(1'h1, SEA_PRIMARY_OFF, 32'h0);
			rchk(SEA_PRIMARY_OFF, 32'h4, {29'h0, |ex[3:0], 2'h0});
			clr(ks[i]);
			ex = ex & ~ms[i];
			rchk(SEA_SECONDARY_OFF, 32'hffffffff, ex);
		end
		set_all;
		rchk(SEA_SUMMARY_OFF, 32'h3f, 32'h3f);
		@(posedge sys_clk);
		twi.arb_lost <= 1'h1;
		isr_clear.twi <= 1'h1;
		seq0.start <= 1'h1;
		seq0.reg_error <= 1'h1;
		strobe;
		rchk(SEA_SECONDARY_OFF, 32'h063e0000, 32'h04040000);
		clr(3);
		rchk(SEA_SUMMARY_OFF, 32'h2, 32'h0);
		$display("test sticky done");
	endtask
	task t_edges;
		logic [5:0] acc;
		apb(1'h1, SEA_EDGE_CFG_OFF, 32'h6c6);
		rchk(SEA_EDGE_CFG_OFF, 32'hffffffff, 32'h6c6);
		for (int i = 0; i < 2; i++) begin
			@(posedge sys_clk);
			{field_id_a, field_id_b} <= {2{i == 0}};
			gp_pin <= {4{i == 0}};
			acc = 6'h0;
			repeat (4) begin
				@(posedge sys_clk);
				acc |= edge_event;
			end
			chk({26'h0, acc}, i ? 32'h19 : 32'h2a);
		end
		$display("test edges done");
	endtask

	initial begin
		{sys_clk, rst_b, psel, penable, pwrite, paddr, pwdata} = 49'h0;
		{field_id_a, field_id_b, gp_pin, counter_over} = 12'h0;
		{bus_req, bus_gnt, bus_master, vdma_reload, vfifo3_xrun_hit} = 5'h0;
		{vdma_prot_hit, seq0, seq1, xbus, twi, isr_clear} = 27'h0;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'h1;
		t_reset;
		t_levels;
		t_sticky;
		t_edges;
		end_of_test;
	end
endmodule
